//--- rtl/nas_pkg.sv
// Shared constants and types for the nibble ALU status-flag block
package nas_pkg;

	// APB and nibble datapath geometry
	localparam int NAS_ADDR_W = 12;
	localparam int NAS_DATA_W = 32;
	localparam int NAS_NIB_W = 4;

	// Register byte addresses
	localparam logic [NAS_ADDR_W-1:0] NAS_ADDR_PSW = 12'h000;
	localparam logic [NAS_ADDR_W-1:0] NAS_ADDR_CMD = 12'h004;
	localparam logic [NAS_ADDR_W-1:0] NAS_ADDR_STAT = 12'h008;

	// Program status word bit positions
	localparam int NAS_PSW_ZERO = 0;
	localparam int NAS_PSW_CARRY = 1;
	localparam int NAS_PSW_NOSTORE = 2;
	localparam int NAS_PSW_DECIMAL = 3;
	localparam logic [NAS_NIB_W-1:0] NAS_PSW_RST = 4'h0;

	// Command register fields
	localparam int NAS_CMD_A_LSB = 0;
	localparam int NAS_CMD_B_LSB = 4;
	localparam int NAS_CMD_OP_LSB = 8;

	// Status register fields
	localparam int NAS_STAT_RES_LSB = 0;
	localparam int NAS_STAT_STORED = 4;
	localparam int NAS_STAT_SKIP = 5;
	localparam int NAS_STAT_BUSY = 6;

	localparam logic [NAS_NIB_W-1:0] NAS_NIB_ZERO = 4'h0;
	localparam logic [NAS_DATA_W-1:0] NAS_WORD_ZERO = 32'h0000_0000;

	// Decimal correction constants
	localparam logic [4:0] NAS_DEC_TEN = 5'h0a;
	localparam logic [4:0] NAS_DEC_TWENTY = 5'h14;
	localparam logic [4:0] NAS_DEC_MINUS_TEN = 5'h16;
	localparam logic [3:0] NAS_DEC_TEN_NIB = 4'ha;
	localparam logic [1:0] NAS_DEC_HI_PAD = 2'h3;
	localparam logic [1:0] NAS_DEC_ALT_PAD = 2'h2;
	localparam logic [1:0] NAS_DEC_SKEW = 2'h2;
	localparam logic [1:0] NAS_DEC_ALT_SEL = 2'h3;

	typedef enum logic [3:0] {
		NAS_OP_ADD = 4'h0,
		NAS_OP_ADD_WITH_CARRY = 4'h1,
		NAS_OP_SUB = 4'h2,
		NAS_OP_SUBTRACT_WITH_BORROW = 4'h3,
		NAS_OP_OR = 4'h4,
		NAS_OP_AND = 4'h5,
		NAS_OP_XOR = 4'h6,
		NAS_OP_SKIP_IF_BITS_TRUE = 4'h7,
		NAS_OP_SKIP_IF_BITS_FALSE = 4'h8,
		NAS_OP_SKIP_EQ = 4'h9,
		NAS_OP_SKIP_NE = 4'ha,
		NAS_OP_SKIP_GE = 4'hb,
		NAS_OP_SKIP_LT = 4'hc,
		NAS_OP_ROTATE_RIGHT_THROUGH_CARRY = 4'hd,
		NAS_OP_NOP_E = 4'he,
		NAS_OP_NOP_F = 4'hf
	} nas_op_e;

	typedef enum logic [1:0] {
		NAS_ST_IDLE = 2'b01,
		NAS_ST_EXEC = 2'b10
	} nas_state_e;

endpackage

//--- rtl/nas_bin_adder.sv
// Raw 5-bit adder/subtractor with carry or borrow injected at bit 0
module nas_bin_adder
	import nas_pkg::*;
(
	input wire logic [NAS_NIB_W-1:0] a_i,
	input wire logic [NAS_NIB_W-1:0] b_i,
	input wire logic carry_in_i,
	input wire logic sub_i,
	output logic [4:0] raw_o
);
	// Subtraction result is two's complement; bit 4 is the borrow
	always_comb
	begin
		if (sub_i)
			raw_o = {1'b0, a_i} - {1'b0, b_i} - {4'h0, carry_in_i};
		else
			raw_o = {1'b0, a_i} + {1'b0, b_i} + {4'h0, carry_in_i};
	end
endmodule

//--- rtl/nas_dec_adjust.sv
// Decimal correction of a raw 5-bit sum or difference
module nas_dec_adjust
	import nas_pkg::*;
(
	input wire logic [4:0] raw_i,
	input wire logic sub_i,
	output logic [NAS_NIB_W-1:0] digit_o,
	output logic carry_o
);
	logic [4:0] less_ten;
	logic [3:0] odd_digit;

	always_comb
	begin
		less_ten = raw_i - NAS_DEC_TEN;
		// Out-of-range results land at 1010B or above, never a legal digit
		if (!sub_i && raw_i[3:2] == NAS_DEC_ALT_SEL && !raw_i[1])
			odd_digit = {NAS_DEC_ALT_PAD, raw_i[1:0] + NAS_DEC_SKEW};
		else
			odd_digit = {NAS_DEC_HI_PAD, raw_i[1:0] + NAS_DEC_SKEW};
		carry_o = 1'b1;
		digit_o = odd_digit;
		if (!sub_i)
		begin
			if (raw_i < NAS_DEC_TEN)
			begin
				carry_o = 1'b0;
				digit_o = raw_i[3:0];
			end
			else if (raw_i < NAS_DEC_TWENTY)
				digit_o = less_ten[3:0];
		end
		else
		begin
			if (!raw_i[4] && raw_i < NAS_DEC_TEN)
			begin
				carry_o = 1'b0;
				digit_o = raw_i[3:0];
			end
			else if (raw_i[4] && raw_i >= NAS_DEC_MINUS_TEN)
				digit_o = raw_i[3:0] + NAS_DEC_TEN_NIB;
		end
	end
endmodule

//--- rtl/nas_core.sv
// Nibble ALU with status flags, operand latches and an APB register port
//
// Functional notes
// - No-store clear: zero set on 0000B, else cleared
// - No-store set: zero kept on 0000B, else cleared
// - Only arithmetic changes the zero flag
// - Arithmetic sets carry on carry/borrow, else clears
// - Carry-using ops inject carry at bit 0
// - Rotate right: carry into b3, b0 into carry
// - Only arithmetic and rotation change carry
// - No-store set: arithmetic result not written back
// - Bit tests clear the no-store flag
// - No-store ignored by compare, logic, rotate
// - Decimal flag selects decimal-corrected arithmetic
// - Decimal flag ignored by non-arithmetic ops
// - Flags are the status word bits themselves
// - Operands latched into temp A and B first
// - Decimal out-of-range results store 1010B or above
// - Decimal correction follows the tabulated mapping
module nas_core
	import nas_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [nas_pkg::NAS_ADDR_W-1:0] paddr_i,
	input wire logic [nas_pkg::NAS_DATA_W-1:0] pwdata_i,
	output logic [nas_pkg::NAS_DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [nas_pkg::NAS_NIB_W-1:0] psw_o,
	output logic wb_en_o,
	output logic [nas_pkg::NAS_NIB_W-1:0] wb_data_o,
	output logic skip_o,
	output logic done_o
);
	import nas_pkg::*;

	typedef struct packed {
		nas_state_e state;
		logic [NAS_NIB_W-1:0] psw;
		logic [NAS_NIB_W-1:0] tmp_a;
		logic [NAS_NIB_W-1:0] tmp_b;
		nas_op_e op;
		logic [NAS_NIB_W-1:0] result;
		logic stored;
		logic skip;
		logic wb_en;
		logic skip_p;
		logic done;
		logic [NAS_DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} nas_core_s;

	localparam nas_core_s NAS_CORE_RST = '{
		state: NAS_ST_IDLE,
		psw: NAS_PSW_RST,
		tmp_a: NAS_NIB_ZERO,
		tmp_b: NAS_NIB_ZERO,
		op: NAS_OP_NOP_F,
		result: NAS_NIB_ZERO,
		stored: 1'b0,
		skip: 1'b0,
		wb_en: 1'b0,
		skip_p: 1'b0,
		done: 1'b0,
		prdata: NAS_WORD_ZERO,
		pready: 1'b0,
		pslverr: 1'b0
	};

	nas_core_s cur_ff;
	nas_core_s nxt_core;

	logic is_arith;
	logic is_sub;
	logic uses_carry;
	logic carry_in;
	logic [4:0] raw;
	logic [NAS_NIB_W-1:0] dec_digit;
	logic dec_carry;
	logic [NAS_NIB_W-1:0] ar_digit;
	logic ar_carry;
	logic [4:0] cmp_diff;
	logic [NAS_NIB_W-1:0] masked;
	logic setup;
	logic access;
	logic busy;
	logic wr_refused;

	// Arithmetic class decode
	always_comb
	begin
		is_arith = 1'b0;
		is_sub = 1'b0;
		uses_carry = 1'b0;
		unique case (cur_ff.op)
			NAS_OP_ADD:
				is_arith = 1'b1;
			NAS_OP_ADD_WITH_CARRY:
			begin
				is_arith = 1'b1;
				uses_carry = 1'b1;
			end
			NAS_OP_SUB:
			begin
				is_arith = 1'b1;
				is_sub = 1'b1;
			end
			NAS_OP_SUBTRACT_WITH_BORROW:
			begin
				is_arith = 1'b1;
				is_sub = 1'b1;
				uses_carry = 1'b1;
			end
			default:
				is_arith = 1'b0;
		endcase
	end

	assign carry_in = uses_carry & cur_ff.psw[NAS_PSW_CARRY];

	nas_bin_adder u_adder (
		.a_i(cur_ff.tmp_a),
		.b_i(cur_ff.tmp_b),
		.carry_in_i(carry_in),
		.sub_i(is_sub),
		.raw_o(raw)
	);

	nas_dec_adjust u_dec (
		.raw_i(raw),
		.sub_i(is_sub),
		.digit_o(dec_digit),
		.carry_o(dec_carry)
	);

	// Decimal path only for arithmetic; other classes never look at it
	always_comb
	begin
		if (cur_ff.psw[NAS_PSW_DECIMAL])
		begin
			ar_digit = dec_digit;
			ar_carry = dec_carry;
		end
		else
		begin
			ar_digit = raw[3:0];
			ar_carry = raw[4];
		end
	end

	// Comparison is always plain binary and never uses the carry flag
	assign cmp_diff = {1'b0, cur_ff.tmp_a} - {1'b0, cur_ff.tmp_b};
	assign masked = cur_ff.tmp_a & cur_ff.tmp_b;

	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i & cur_ff.pready;
	assign busy = (cur_ff.state == NAS_ST_EXEC);
	// A command arriving while one is in flight would corrupt the latches
	assign wr_refused = pwrite_i & (paddr_i == NAS_ADDR_CMD) & busy;

	always_comb
	begin
		nxt_core = cur_ff;
		nxt_core.wb_en = 1'b0;
		nxt_core.skip_p = 1'b0;
		nxt_core.done = 1'b0;

		// Bus setup: decide the answer one cycle ahead, zero wait states
		if (setup)
		begin
			nxt_core.pready = 1'b1;
			nxt_core.pslverr = wr_refused;
			nxt_core.prdata = NAS_WORD_ZERO;
			unique case (paddr_i)
				NAS_ADDR_PSW:
					nxt_core.prdata[NAS_NIB_W-1:0] = cur_ff.psw;
				NAS_ADDR_CMD:
				begin
					nxt_core.prdata[NAS_CMD_A_LSB +: NAS_NIB_W] = cur_ff.tmp_a;
					nxt_core.prdata[NAS_CMD_B_LSB +: NAS_NIB_W] = cur_ff.tmp_b;
					nxt_core.prdata[NAS_CMD_OP_LSB +: NAS_NIB_W] = cur_ff.op;
				end
				NAS_ADDR_STAT:
				begin
					nxt_core.prdata[NAS_STAT_RES_LSB +: NAS_NIB_W] = cur_ff.result;
					nxt_core.prdata[NAS_STAT_STORED] = cur_ff.stored;
					nxt_core.prdata[NAS_STAT_SKIP] = cur_ff.skip;
					nxt_core.prdata[NAS_STAT_BUSY] = busy;
				end
				default:
					nxt_core.pslverr = 1'b1;
			endcase
		end

		// Access edge: the only edge where a write takes effect
		if (access)
		begin
			nxt_core.pready = 1'b0;
			nxt_core.pslverr = 1'b0;
			if (pwrite_i && !cur_ff.pslverr)
			begin
				if (paddr_i == NAS_ADDR_PSW)
					nxt_core.psw = pwdata_i[NAS_NIB_W-1:0];
				else if (paddr_i == NAS_ADDR_CMD)
				begin
					nxt_core.tmp_a = pwdata_i[NAS_CMD_A_LSB +: NAS_NIB_W];
					nxt_core.tmp_b = pwdata_i[NAS_CMD_B_LSB +: NAS_NIB_W];
					nxt_core.op = nas_op_e'(pwdata_i[NAS_CMD_OP_LSB +: NAS_NIB_W]);
					nxt_core.state = NAS_ST_EXEC;
				end
			end
		end

		// Execute from the latched operands; flag updates win over a
		// software status-word write landing on the same edge
		if (busy)
		begin
			nxt_core.state = NAS_ST_IDLE;
			nxt_core.done = 1'b1;
			nxt_core.stored = 1'b0;
			nxt_core.skip = 1'b0;
			if (is_arith)
			begin
				nxt_core.result = ar_digit;
				nxt_core.psw[NAS_PSW_CARRY] = ar_carry;
				if (ar_digit != NAS_NIB_ZERO)
					nxt_core.psw[NAS_PSW_ZERO] = 1'b0;
				else if (!cur_ff.psw[NAS_PSW_NOSTORE])
					nxt_core.psw[NAS_PSW_ZERO] = 1'b1;
				else
					nxt_core.psw[NAS_PSW_ZERO] = cur_ff.psw[NAS_PSW_ZERO];
				nxt_core.stored = ~cur_ff.psw[NAS_PSW_NOSTORE];
			end
			else
			begin
				// Zero flag kept here; no-store has no say in these classes
				unique case (cur_ff.op)
					NAS_OP_OR:
					begin
						nxt_core.result = cur_ff.tmp_a | cur_ff.tmp_b;
						nxt_core.stored = 1'b1;
					end
					NAS_OP_AND:
					begin
						nxt_core.result = masked;
						nxt_core.stored = 1'b1;
					end
					NAS_OP_XOR:
					begin
						nxt_core.result = cur_ff.tmp_a ^ cur_ff.tmp_b;
						nxt_core.stored = 1'b1;
					end
					NAS_OP_SKIP_IF_BITS_TRUE:
					begin
						nxt_core.psw[NAS_PSW_NOSTORE] = 1'b0;
						nxt_core.skip = (masked == cur_ff.tmp_b);
					end
					NAS_OP_SKIP_IF_BITS_FALSE:
					begin
						nxt_core.psw[NAS_PSW_NOSTORE] = 1'b0;
						nxt_core.skip = (masked == NAS_NIB_ZERO);
					end
					NAS_OP_SKIP_EQ:
						nxt_core.skip = (cmp_diff[3:0] == NAS_NIB_ZERO);
					NAS_OP_SKIP_NE:
						nxt_core.skip = (cmp_diff[3:0] != NAS_NIB_ZERO);
					NAS_OP_SKIP_GE:
						nxt_core.skip = ~cmp_diff[4];
					NAS_OP_SKIP_LT:
						nxt_core.skip = cmp_diff[4];
					NAS_OP_ROTATE_RIGHT_THROUGH_CARRY:
					begin
						nxt_core.result = {cur_ff.psw[NAS_PSW_CARRY], cur_ff.tmp_a[3:1]};
						nxt_core.psw[NAS_PSW_CARRY] = cur_ff.tmp_a[0];
						nxt_core.stored = 1'b1;
					end
					default:
						nxt_core.stored = 1'b0;
				endcase
			end
			nxt_core.wb_en = nxt_core.stored;
			nxt_core.skip_p = nxt_core.skip;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cur_ff <= NAS_CORE_RST;
		else
			cur_ff <= nxt_core;
	end

	assign prdata_o = cur_ff.prdata;
	assign pready_o = cur_ff.pready;
	assign pslverr_o = cur_ff.pslverr;
	assign psw_o = cur_ff.psw;
	assign wb_en_o = cur_ff.wb_en;
	assign wb_data_o = cur_ff.result;
	assign skip_o = cur_ff.skip_p;
	assign done_o = cur_ff.done;
endmodule

//--- tb/nas_core_properties.sv
// Concurrent checks on the nibble ALU flag block ports
module nas_core_properties
	import nas_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [3:0] psw_o,
	input wire logic wb_en_o,
	input wire logic [3:0] wb_data_o,
	input wire logic done_o
);
	logic [15:0] cmd_ff;
	logic [3:0] a, b, op, p;
	logic go, ar;
	logic [4:0] sum;
	assign go = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o
		&& paddr_i == NAS_ADDR_CMD;
	// Status word is captured at issue; no status write is expected while busy
	always_ff @(posedge sys_clk_i or negedge resetn_i)
		if (!resetn_i)
			cmd_ff <= 16'h0000;
		else if (go)
			cmd_ff <= {psw_o, pwdata_i[11:0]};
	assign {p, op, b, a} = cmd_ff;
	assign ar = op < 4'h4;
	assign sum = op[1] ? a - b - (op[0] & p[1]) : a + b + (op[0] & p[1]);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	property p_issue; go |-> ##2 done_o; endproperty
	a_issue: assert property (p_issue) else $error("no finish after issue");
	property p_zset; done_o && ar && !p[2] |-> psw_o[0] == (wb_data_o == 4'h0); endproperty
	a_zset: assert property (p_zset) else $error("zero flag wrong");
	property p_zkeep; done_o && ar && p[2] |-> psw_o[0] == (wb_data_o == 4'h0 && p[0]); endproperty
	a_zkeep: assert property (p_zkeep) else $error("zero flag not kept");
	property p_zhold; done_o && !ar |-> psw_o[0] == p[0]; endproperty
	a_zhold: assert property (p_zhold) else $error("zero flag moved");
	property p_chold; done_o && !ar && op != 4'hd |-> psw_o[1] == p[1]; endproperty
	a_chold: assert property (p_chold) else $error("carry moved");
	property p_rot; done_o && op == 4'hd |-> wb_en_o && psw_o[1] == a[0]
		&& wb_data_o == {p[1], a[3:1]}; endproperty
	a_rot: assert property (p_rot) else $error("rotate wrong");
	property p_nost; done_o && ar |-> wb_en_o == !p[2]; endproperty
	a_nost: assert property (p_nost) else $error("store gating wrong");
	property p_btest; done_o && op inside {4'h7, 4'h8} |-> !psw_o[2] && !wb_en_o; endproperty
	a_btest: assert property (p_btest) else $error("bit test left flag");
	property p_bin; done_o && ar && !p[3] |-> {psw_o[1], wb_data_o} == sum; endproperty
	a_bin: assert property (p_bin) else $error("binary result wrong");
	property p_logic; done_o && op inside {4'h4, 4'h5, 4'h6} |-> wb_en_o && psw_o == p; endproperty
	a_logic: assert property (p_logic) else $error("logic op flags");
	// Out-of-range decimal sums and differences must never look like a digit
	property p_dec; done_o && ar && p[3] && (op[1] ? sum inside {[5'h0a:5'h15]}
		: sum >= 5'h14) |-> wb_data_o >= 4'ha; endproperty
	a_dec: assert property (p_dec) else $error("decimal range wrong");
	c_nost: cover property (done_o && ar && p[2]);
	c_dec: cover property (done_o && ar && p[3]);
	c_rot: cover property (done_o && op == 4'hd);
endmodule

bind nas_core nas_core_properties nas_core_properties_i (.sys_clk_i, .resetn_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .psw_o, .wb_en_o,
	.wb_data_o, .done_o);

//--- tb/nas_seq_model.sv
// Sequencer model issuing register-bus transfers for the bench
module nas_seq_model
(
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [11:0] paddr_o,
	output logic [31:0] pwdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0000_0000;
	end
	// Gives up after eight edges so a dead slave cannot hang the run
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic ok);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_i !== 1'b1 && n < 8);
		r = prdata_i;
		e = pslverr_i;
		ok = pready_i === 1'b1;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines flip so stale values never look live
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask
endmodule

//--- tb/test_nibble_alu_status_flags.sv
// Self-checking bench for the nibble ALU flag block
module test_nibble_alu_status_flags;
	import nas_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic wb_en_o, skip_o, done_o;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [3:0] psw_o, wb_data_o;
	int failures, tests_run, seed;
	logic [15:0] corner [8] = '{16'h8019, 16'h8210, 16'ha1ff, 16'h5000, 16'h4000, 16'h4777,
		16'h2d01, 16'h2333};
	initial
	begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	nas_core nas_core_i (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .psw_o, .wb_en_o, .wb_data_o, .skip_o,
		.done_o);
	nas_seq_model nas_seq_model_i (.clk_i(sys_clk_i), .pready_i(pready_o),
		.pslverr_i(pslverr_o), .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i),
		.pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		logic ok;
		nas_seq_model_i.xfer(w, a, d, r, e, ok);
		if (!ok)
		begin
			failures++;
			finish_test();
		end
	endtask
	function automatic void model(input logic [3:0] a, b, op, p, output logic [3:0] np, res,
		output logic wb, sk);
		logic [4:0] u, t;
		np = p;
		res = 4'h0;
		sk = 1'b0;
		u = op[1] ? a - b - (op[0] & p[1]) : a + b + (op[0] & p[1]);
		t = u + 5'h02;
		case (op)
			4'h0, 4'h1, 4'h2, 4'h3:
			begin
				res = u[3:0];
				np[1] = u[4];
				if (p[3])
				begin
					np[1] = op[1] ? u > 5'h09 : u > 5'h09;
					if (!op[1])
						res = u < 5'h0a ? u[3:0] : u < 5'h14 ? u[3:0] + 4'h6
							: {u == 5'h1c || u == 5'h1d ? 2'h2 : 2'h3, t[1:0]};
					else
						res = u < 5'h0a ? u[3:0] : u > 5'h15 ? u[3:0] + 4'ha : {2'h3, t[1:0]};
				end
				np[0] = res == 4'h0 && (!p[2] || p[0]);
			end
			4'h4: res = a | b;
			4'h5: res = a & b;
			4'h6: res = a ^ b;
			4'h7: sk = (a & b) == b;
			4'h8: sk = (a & b) == 4'h0;
			4'h9: sk = a == b;
			4'ha: sk = a != b;
			4'hb: sk = a >= b;
			4'hc: sk = a < b;
			4'hd:
			begin
				res = {p[1], a[3:1]};
				np[1] = a[0];
			end
			default: ;
		endcase
		if (op inside {4'h7, 4'h8})
			np[2] = 1'b0;
		wb = op inside {4'h4, 4'h5, 4'h6, 4'hd} || (op < 4'h4 && !p[2]);
	endfunction
	initial
	begin
		logic [31:0] r;
		logic e, wb, sk;
		logic [3:0] a, b, op, p, np, res;
		int n;
		failures = 0;
		tests_run = 0;
		seed = 2;
		resetn_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		chk(psw_o, 32'h0, "reset psw");
		bus(1'b0, 12'hffc, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h8000_0000, "unmapped");
		for (int i = 0; i < 300; i++)
		begin
			{p, op, b, a} = i < 8 ? corner[i] : 16'($random(seed));
			bus(1'b1, NAS_ADDR_PSW, {28'h0, p}, r, e);
			bus(1'b1, NAS_ADDR_CMD, {20'h0, op, b, a}, r, e);
			n = 0;
			do
			begin
				@(posedge sys_clk_i);
				n++;
			end
			while (done_o !== 1'b1 && n < 8);
			if (done_o !== 1'b1)
			begin
				failures++;
				finish_test();
			end
			model(a, b, op, p, np, res, wb, sk);
			chk(psw_o, np, "flags");
			chk({wb_en_o, skip_o}, {wb, sk}, "store skip");
			if (wb || op < 4'h4)
				chk(wb_data_o, res, "result");
			bus(1'b0, NAS_ADDR_PSW, 32'h0, r, e);
			chk(r, np, "psw read");
			bus(1'b0, NAS_ADDR_STAT, 32'h0, r, e);
			chk(r[6:4], {1'b0, sk, wb}, "status read");
		end
		finish_test();
	end
endmodule
